// file: spi_port.sv
`timescale 1ns/10ps
// Function
// [R1] Slave: select is input; when low port active, MISO driven only if user allows.
// [R2] Slave select high: port passive, shift logic reset, partial bits dropped.
// [R3] Master with select as output: select pin is plain output, no SPI effect.
// [R4] Master with select as input: external logic keeps it high.
// [R5] Select low as input in master: clear master, go slave, set done flag.
// [R6] After mode fault software sets master again and checks it.
// [R7] Control bit 7 enables interrupt; request when enable, done flag, global enable.
// [R8] Control bit 6 enables port; no operation without it.
// [R9] Control bit 5 set shifts LSB first, else MSB first.
// [R10] Control bit 4 selects master when one, slave when zero.
// [R11] Control bit 3 sets SCK idle level and leading edge direction.
// [R12] Control bit 2: phase 0 sample leading; phase 1 sample trailing.
// [R13] Master SCK divide by 4,16,64,128 or with doubling 2,8,32,64.
// [R14] Rate bits have no effect in slave operation.
// [R15] Status bit 7 done flag set at byte end and on mode fault.
// [R16] Done flag cleared by vector taken or status read then data access.
// [R17] Status bit 6 collision flag set on data write during transfer.
// [R18] Status read seeing collision then data access clears both flags.
// [R19] Status bits 5 to 1 read zero.
// [R20] Status bit 0 doubles master SCK rate; shortest period two clocks.
// [R21] External master keeps SCK at or below quarter of system clock.
// [R22] Data write starts transfer; data read returns receive buffer.
// [R23] Shift and sample on opposite edges; polarity-phase pairs are modes 0 to 3.
// [R24] Master: data write starts clock, eight bits, clock stops, done flag set.
// [R25] Slave idle with MISO off while select high, even if data loaded.
// [R26] Transmit single buffer, receive double buffer; unread byte overwritten.
// [R27] Slave SCK and select pass two-stage synchroniser and edge detector.
`include "spi_port_params.svh"

module spi_port
  import spi_port_pkg::*;
(
  // Clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_resetn,
  // Register port
  input  wire logic [1:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // CPU side
  input  wire logic       i_global_irq_en,
  input  wire logic       i_irq_ack,
  output logic            o_irq,
  // Pin direction choices from the user
  input  wire logic       i_sel_is_output,
  input  wire logic       i_sel_gpio_val,
  input  wire logic       i_mosi_dir_out,
  input  wire logic       i_miso_dir_out,
  input  wire logic       i_sck_dir_out,
  // SPI pins; enables low while driven
  input  wire logic       i_sck,
  output logic            o_sck,
  output logic            o_sck_oe_n,
  input  wire logic       i_mosi,
  output logic            o_mosi,
  output logic            o_mosi_oe_n,
  input  wire logic       i_miso,
  output logic            o_miso,
  output logic            o_miso_oe_n,
  input  wire logic       i_sel_n,
  output logic            o_sel_n,
  output logic            o_sel_oe_n
);

  ctrl_s       ctrl_r;
  logic        double_r;
  logic        done_r;
  logic        write_collision_flag_r;
  logic        armed_r;
  logic [7:0]  shift_r;
  logic [7:0]  rxbuf_r;
  logic [2:0]  bitcnt_r;
  logic        half_r;
  logic [6:0]  div_r;
  logic        sck_r;
  logic        out_r;
  xfer_state_e state_r;

  // Synchronisers: first stage read only by second
  spi_lines_s  pin_s1_r;
  spi_lines_s  pin_s2_r;
  logic        sel_s1_r;
  logic        sel_s2_r;
  logic        sck_d_r;
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      sel_s1_r <= 1'b1;
      sel_s2_r <= 1'b1;
      sck_d_r  <= 1'b0;
    end else begin
      pin_s1_r <= '{sck: i_sck, mosi: i_mosi, miso: i_miso};   // [R27]
      pin_s2_r <= pin_s1_r;
      sel_s1_r <= i_sel_n;
      sel_s2_r <= sel_s1_r;
      sck_d_r  <= pin_s2_r.sck;
    end
  end

  logic is_master;
  logic is_slave_act;
  logic fault;
  logic sck_edge;
  logic lead_edge;
  logic sample_edge;
  logic shift_edge;
  logic data_wr;
  logic data_acc;
  logic sts_rd;
  logic byte_end;
  logic slave_in_bit;
  logic [6:0] div_max;
  logic       xfer_busy;

  assign is_master    = ctrl_r.port_en && ctrl_r.master;                   // [R8] [R10]
  assign is_slave_act = ctrl_r.port_en && !ctrl_r.master && !sel_s2_r;     // [R1]
  assign fault        = is_master && !i_sel_is_output && !sel_s2_r;        // [R5] [R3]
  assign sck_edge     = pin_s2_r.sck != sck_d_r;                           // [R27]
  // Leading edge leaves the idle level
  assign lead_edge    = sck_edge && (pin_s2_r.sck != ctrl_r.clock_polarity);         // [R11]
  assign sample_edge  = sck_edge && (lead_edge != ctrl_r.clock_phase);            // [R12] [R23]
  assign shift_edge   = sck_edge && (lead_edge == ctrl_r.clock_phase);            // [R23]
  assign data_wr      = i_wr && i_addr == `OFS_DATA;
  assign data_acc     = (i_wr || i_rd) && i_addr == `OFS_DATA;
  assign sts_rd       = i_rd && i_addr == `OFS_STATUS;
  assign xfer_busy    = state_r != ST_IDLE;
  assign slave_in_bit = ctrl_r.lsb_first ? shift_r[0] : shift_r[7];

  // Half-period count minus one per rate setting
  always_comb begin
    case ({double_r, ctrl_r.rate_hi, ctrl_r.rate_lo})                     // [R13] [R20]
      3'h0:    div_max = 7'h01;
      3'h1:    div_max = 7'h07;
      3'h2:    div_max = 7'h1f;
      3'h3:    div_max = 7'h3f;
      3'h4:    div_max = 7'h00;
      3'h5:    div_max = 7'h03;
      3'h6:    div_max = 7'h0f;
      default: div_max = 7'h1f;
    endcase
  end

  // Byte completes on the eighth trailing edge as master, eighth sampling point as slave
  assign byte_end = (state_r == ST_MASTER && div_r == div_max && half_r &&
                     bitcnt_r == 3'h7) ||
                    (state_r == ST_SLAVE && sample_edge && bitcnt_r == 3'h7 &&
                     !sel_s2_r);

  // Control register; mode fault clears master
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_r   <= `CONTROL_RST;
      double_r <= `DOUBLE_RST;
    end else begin
      if (i_wr && i_addr == `OFS_CONTROL) begin
        ctrl_r <= i_wdata;
      end
      if (i_wr && i_addr == `OFS_STATUS) begin
        double_r <= i_wdata[`STS_DOUBLE];
      end
      if (fault) begin
        ctrl_r.master <= 1'b0;                                             // [R5]
      end
    end
  end

  // Armed after a status read that saw a flag set
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      armed_r <= 1'b0;
    end else if (sts_rd) begin
      armed_r <= done_r || write_collision_flag_r;                                         // [R16] [R18]
    end else if (data_acc) begin
      armed_r <= 1'b0;
    end
  end

  // Flags: set wins over clear
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      done_r <= 1'b0;
      write_collision_flag_r <= 1'b0;
    end else begin
      if (byte_end || fault) begin
        done_r <= 1'b1;                                                    // [R15] [R24]
      end else if (i_irq_ack || (armed_r && data_acc)) begin
        done_r <= 1'b0;                                                    // [R16] [R18]
      end
      if (data_wr && xfer_busy) begin
        write_collision_flag_r <= 1'b1;                                                    // [R17]
      end else if (armed_r && data_acc) begin
        write_collision_flag_r <= 1'b0;                                                    // [R18]
      end
    end
  end

  // Transfer engine
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_r  <= ST_IDLE;
      shift_r  <= `DATA_RST;
      bitcnt_r <= 3'h0;
      half_r   <= 1'b0;
      div_r    <= 7'h00;
      sck_r    <= 1'b0;
      out_r    <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          sck_r  <= ctrl_r.clock_polarity;                                           // [R11]
          div_r  <= 7'h00;
          half_r <= 1'b0;
          if (data_wr) begin
            shift_r <= i_wdata;                                            // [R22] [R25]
          end
          if (is_master && data_wr && !fault) begin
            state_r  <= ST_MASTER;                                         // [R24]
            bitcnt_r <= 3'h0;
            out_r    <= ctrl_r.lsb_first ? i_wdata[0] : i_wdata[7];        // [R9]
          end else if (is_slave_act && !fault) begin
            state_r  <= ST_SLAVE;
            bitcnt_r <= 3'h0;
            out_r    <= ctrl_r.lsb_first ? shift_r[0] : shift_r[7];        // [R9]
          end
        end
        ST_MASTER: begin
          if (fault || !ctrl_r.port_en) begin
            state_r <= ST_IDLE;                                            // [R5] [R8]
          end else if (div_r == div_max) begin
            div_r  <= 7'h00;
            sck_r  <= ~sck_r;
            half_r <= ~half_r;
            // First half ends on leading edge, second on trailing edge
            if (half_r == ctrl_r.clock_phase) begin
              if (ctrl_r.lsb_first) begin
                shift_r <= {pin_s2_r.miso, shift_r[7:1]};                  // [R9] [R12]
              end else begin
                shift_r <= {shift_r[6:0], pin_s2_r.miso};
              end
            end
            if (half_r) begin
              bitcnt_r <= bitcnt_r + 3'h1;
              if (bitcnt_r == 3'h7) begin
                state_r <= ST_IDLE;                                        // [R24]
              end
            end
            if (half_r != ctrl_r.clock_phase) begin
              out_r <= ctrl_r.lsb_first ? shift_r[0] : shift_r[7];         // [R23]
            end
          end else begin
            div_r <= div_r + 7'h01;                                        // [R13]
          end
        end
        ST_SLAVE: begin
          if (sel_s2_r || !ctrl_r.port_en || ctrl_r.master) begin
            state_r  <= ST_IDLE;                                           // [R2]
            bitcnt_r <= 3'h0;
          end else begin
            if (data_wr && !xfer_busy) begin
              shift_r <= i_wdata;
            end
            if (sample_edge) begin
              if (ctrl_r.lsb_first) begin
                shift_r <= {pin_s2_r.mosi, shift_r[7:1]};                  // [R9] [R12]
              end else begin
                shift_r <= {shift_r[6:0], pin_s2_r.mosi};
              end
              bitcnt_r <= bitcnt_r + 3'h1;
            end
            if (shift_edge) begin
              out_r <= slave_in_bit;                                       // [R23] [R14]
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Receive buffer loaded when a byte completes
  logic [7:0] rx_byte;
  always_comb begin
    if (state_r == ST_MASTER && !ctrl_r.clock_phase) begin
      // Phase 0 took its last bit on the leading edge already
      rx_byte = shift_r;
    end else if (state_r == ST_MASTER) begin
      rx_byte = ctrl_r.lsb_first ? {pin_s2_r.miso, shift_r[7:1]}
                                 : {shift_r[6:0], pin_s2_r.miso};
    end else begin
      rx_byte = ctrl_r.lsb_first ? {pin_s2_r.mosi, shift_r[7:1]}
                                 : {shift_r[6:0], pin_s2_r.mosi};
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rxbuf_r <= `DATA_RST;
    end else if (byte_end) begin
      rxbuf_r <= rx_byte;                                                  // [R26]
    end
  end

  // Read data one cycle after read strobe
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        `OFS_CONTROL: o_rdata <= ctrl_r;
        `OFS_STATUS:  o_rdata <= {done_r, write_collision_flag_r, 5'h00, double_r};       // [R19]
        `OFS_DATA:    o_rdata <= rxbuf_r;                                  // [R22]
        default:      o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // Pin drive, interrupt
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_irq       <= 1'b0;
      o_sck       <= 1'b0;
      o_sck_oe_n  <= 1'b1;
      o_mosi      <= 1'b0;
      o_mosi_oe_n <= 1'b1;
      o_miso      <= 1'b0;
      o_miso_oe_n <= 1'b1;
      o_sel_n     <= 1'b1;
      o_sel_oe_n  <= 1'b1;
    end else begin
      o_irq       <= ctrl_r.irq_en && done_r && i_global_irq_en;           // [R7]
      o_sck       <= sck_r;
      o_sck_oe_n  <= !(is_master && !fault && i_sck_dir_out);              // [R5]
      o_mosi      <= out_r;
      o_mosi_oe_n <= !(is_master && !fault && i_mosi_dir_out);
      o_miso      <= out_r;
      o_miso_oe_n <= !(is_slave_act && i_miso_dir_out);                    // [R1] [R25]
      o_sel_n     <= i_sel_gpio_val;                                       // [R3]
      o_sel_oe_n  <= !(is_master && i_sel_is_output);                      // [R3]
    end
  end

  a_fault_clears_master: assert property (                                 // [R5]
    @(posedge i_sys_clk) disable iff (!i_resetn)
    fault |=> !ctrl_r.master && done_r)
    else $error("mode fault did not drop master and set done");

  a_slave_deselect: assert property (                                      // [R2]
    @(posedge i_sys_clk) disable iff (!i_resetn)
    (state_r == ST_SLAVE && sel_s2_r) |=> state_r == ST_IDLE && bitcnt_r == 3'h0)
    else $error("slave not reset on deselect");

  a_status_reserved: assert property (                                     // [R19]
    @(posedge i_sys_clk) disable iff (!i_resetn)
    (i_rd && i_addr == `OFS_STATUS) |=> o_rdata[5:1] == 5'h00)
    else $error("reserved status bits not zero");

  a_write_collision_flag_set: assert property (                                            // [R17]
    @(posedge i_sys_clk) disable iff (!i_resetn)
    (data_wr && xfer_busy) |=> write_collision_flag_r)
    else $error("collision flag not set");

  a_done_on_end: assert property (                                         // [R15]
    @(posedge i_sys_clk) disable iff (!i_resetn)
    byte_end |=> done_r)
    else $error("done flag not set at byte end");

  a_irq_gating: assert property (                                          // [R7]
    @(posedge i_sys_clk) disable iff (!i_resetn)
    o_irq == ($past(done_r) && $past(ctrl_r.irq_en) && $past(i_global_irq_en)))
    else $error("interrupt not raised");

  a_slave_miso_off: assert property (                                      // [R25]
    @(posedge i_sys_clk) disable iff (!i_resetn)
    (sel_s2_r && !ctrl_r.master) |=> o_miso_oe_n)
    else $error("miso driven while deselected");

  a_disabled_idle: assert property (                                       // [R8]
    @(posedge i_sys_clk) disable iff (!i_resetn)
    (!ctrl_r.port_en && state_r == ST_IDLE) |=> state_r == ST_IDLE)
    else $error("transfer started while disabled");

endmodule // spi_port

// file: spi_port_params.svh
`ifndef SPI_PORT_PARAMS_SVH
`define SPI_PORT_PARAMS_SVH

// Register offsets on the plain register port
`define OFS_CONTROL     2'h0
`define OFS_STATUS      2'h1
`define OFS_DATA        2'h2

// Control register field positions
`define CTL_IRQ_EN      7
`define CTL_PORT_EN     6
`define CTL_LSB_FIRST   5
`define CTL_MASTER      4
`define CTL_CLOCK_POLARITY        3
`define CTL_CLOCK_PHASE        2
`define CTL_RATE_HI     1
`define CTL_RATE_LO     0

// Status register field positions
`define STS_DONE        7
`define STS_WRITE_COLLISION_FLAG        6
`define STS_DOUBLE      0

// Reset values
`define CONTROL_RST     8'h00
`define DOUBLE_RST      1'b0
`define DATA_RST        8'h00

// Bits in a byte
`define BITS_PER_BYTE   4'h8

`endif

// file: spi_port_pkg.sv
package spi_port_pkg;

  typedef struct packed {
    logic irq_en;
    logic port_en;
    logic lsb_first;
    logic master;
    logic clock_polarity;
    logic clock_phase;
    logic rate_hi;
    logic rate_lo;
  } ctrl_s;

  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
  } spi_lines_s;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_MASTER,
    ST_SLAVE
  } xfer_state_e;

endpackage

// file: spi_peer_model.sv
`timescale 1ns/10ps
module spi_peer_model (
  // Pins seen from the far side
  input  wire logic       i_sck,
  input  wire logic       i_mosi,
  input  wire logic       i_sel_n,
  // Frame format and byte to send
  input  wire logic       i_clock_polarity,
  input  wire logic       i_clock_phase,
  input  wire logic       i_lsb,
  input  wire logic [7:0] i_tx,
  // Reply and captured byte
  output logic            o_miso,
  output logic      [7:0] o_rx
);
  int   tidx;
  int   ridx;
  logic lead;

  function automatic int pos(input int i);
    return i_lsb ? i : 7 - i;
  endfunction

  initial begin
    o_miso = 1'b0;
    o_rx   = 8'h00;
  end

  // A released line shows the inverse of its last level, never a held value
  always @(i_sel_n) begin
    if (!i_sel_n) begin
      tidx   = i_clock_phase ? -1 : 0;
      ridx   = 0;
      o_miso = i_clock_phase ? ~o_miso : i_tx[pos(0)];
    end else begin
      o_miso = ~o_miso;
    end
  end

  always @(i_sck) begin
    if (!i_sel_n) begin
      lead = (i_sck != i_clock_polarity);
      if (lead == !i_clock_phase) begin
        if (ridx < 8) o_rx[pos(ridx)] = i_mosi;
        ridx++;
      end else begin
        tidx++;
        if (tidx < 8) o_miso = i_tx[pos(tidx)];
      end
    end
  end
endmodule // spi_peer_model

// file: spi_master_slave_port_test.sv
`timescale 1ns/10ps
module spi_master_slave_port_test;
  import spi_port_pkg::*;
  logic        clk, resetn, wr_s, rd_s, gie, ack, irq, sel_out, sel_val;
  logic        mosi_dir, miso_dir, sck_dir, ext_sck, ext_mosi, sel_drv, sck_q;
  logic        o_sck, sck_oe_n, o_mosi, mosi_oe_n, o_miso, miso_oe_n, o_sel_n, sel_oe_n;
  logic        peer_miso, dbl;
  logic [1:0]  addr;
  logic [7:0]  wdata, rdata, peer_tx, peer_rx, got, sb, d1;
  logic [31:0] lfsr_r;
  ctrl_s       ctl;
  int          fail_count, check_count, hp, hcnt;
  int          div_tab [8] = '{4, 16, 64, 128, 2, 8, 32, 64};
  wire         sck_w  = sck_oe_n  ? ext_sck   : o_sck;
  wire         mosi_w = mosi_oe_n ? ext_mosi  : o_mosi;
  wire         miso_w = miso_oe_n ? peer_miso : o_miso;
  wire         sel_w  = sel_oe_n  ? sel_drv   : o_sel_n;

  spi_port dut_u (.i_sys_clk(clk), .i_resetn(resetn), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .i_global_irq_en(gie), .i_irq_ack(ack),
    .o_irq(irq), .i_sel_is_output(sel_out), .i_sel_gpio_val(sel_val),
    .i_mosi_dir_out(mosi_dir), .i_miso_dir_out(miso_dir), .i_sck_dir_out(sck_dir),
    .i_sck(sck_w), .o_sck(o_sck), .o_sck_oe_n(sck_oe_n), .i_mosi(mosi_w), .o_mosi(o_mosi),
    .o_mosi_oe_n(mosi_oe_n), .i_miso(miso_w), .o_miso(o_miso), .o_miso_oe_n(miso_oe_n),
    .i_sel_n(sel_w), .o_sel_n(o_sel_n), .o_sel_oe_n(sel_oe_n));

  spi_peer_model peer_u (.i_sck(sck_w), .i_mosi(mosi_w), .i_sel_n(sel_oe_n | o_sel_n),
    .i_clock_polarity(ctl.clock_polarity), .i_clock_phase(ctl.clock_phase), .i_lsb(ctl.lsb_first), .i_tx(peer_tx),
    .o_miso(peer_miso), .o_rx(peer_rx));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Cycles between serial clock toggles
  always @(posedge clk) begin
    hcnt  <= (o_sck != sck_q) ? 1 : hcnt + 1;
    if (o_sck != sck_q) hp <= hcnt;
    sck_q <= o_sck;
  end

  function automatic logic [7:0] rnd();
    lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
    return lfsr_r[7:0];
  endfunction

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic wait_done(output logic [7:0] s);
    int n;
    n = 0;
    s = 8'h00;
    while (s[7] !== 1'b1 && n < 2000) begin
      rd(2'h1, s);
      n++;
    end
  endtask

  // Master byte exchange with the peer; select is a plain output here
  task automatic mxfer(input logic [7:0] d, input logic [7:0] t, input bit ck_rx);
    peer_tx = t;
    @(posedge clk);
    sel_val <= 1'b0;
    wr(2'h2, d);
    chk({6'h00, sel_oe_n, o_sel_n}, 8'h00);
    wait_done(sb);
    chk(sb, {7'h40, dbl});
    rd(2'h2, got);
    if (ck_rx) chk(got, t);
    chk(peer_rx, d);
    rd(2'h1, sb);
    chk(sb, {7'h00, dbl});
    @(posedge clk);
    sel_val <= 1'b1;
  endtask

  // Bench acts as an external master, mode 0, msb first
  task automatic sxfer(input logic [7:0] d, input int nb, output logic [7:0] mi);
    @(posedge clk);
    sel_drv <= 1'b0;
    repeat (6) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      ext_mosi <= d[7-i];
      // Slave needs four cycles from a falling edge to a new MISO bit
      repeat (5) @(posedge clk);
      ext_sck  <= 1'b1;
      mi[7-i] = miso_w;
      repeat (4) @(posedge clk);
      ext_sck  <= 1'b0;
    end
    repeat (6) @(posedge clk);
    sel_drv <= 1'b1;
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #300000;
    fail_count++;
    end_sim();
  end

  initial begin
    {wr_s, rd_s, gie, ack, ext_sck, ext_mosi, sck_q, hcnt, hp} = '0;
    {sel_out, sel_val, mosi_dir, miso_dir, sck_dir, sel_drv} = 6'h3f;
    addr = 2'h0;
    wdata = 8'h00;
    peer_tx = 8'h00;
    dbl = 1'b0;
    ctl = ctrl_s'(8'h00);
    lfsr_r = 32'h2a03;
    fail_count = 0;
    check_count = 0;
    resetn = 1'b0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    for (int a = 0; a < 4; a++) begin
      rd(a[1:0], got);
      chk(got, 8'h00);
    end
    $display("test reset done");
    for (int m = 0; m < 8; m++) begin
      ctl = ctrl_s'({2'b01, m[2], 1'b1, m[1], m[0], 2'b01});
      wr(2'h0, ctl);
      repeat (3) @(posedge clk);
      chk({7'h00, o_sck}, {7'h00, ctl.clock_polarity});
      mxfer(rnd(), rnd(), 1'b1);
    end
    $display("test modes done");
    for (int r = 0; r < 8; r++) begin
      dbl = r[2];
      wr(2'h1, {7'h00, dbl});
      ctl = ctrl_s'({6'b010100, r[1:0]});
      wr(2'h0, ctl);
      mxfer(rnd(), rnd(), div_tab[r] >= 8);
      chk(8'(hp), 8'(div_tab[r] / 2));
    end
    dbl = 1'b0;
    wr(2'h1, 8'h00);
    $display("test rates done");
    d1 = rnd();
    @(posedge clk);
    sel_val <= 1'b0;
    wr(2'h2, d1);
    wr(2'h2, rnd());
    wait_done(sb);
    chk(sb, 8'hc0);
    rd(2'h2, got);
    chk(peer_rx, d1);
    rd(2'h1, sb);
    chk(sb, 8'h00);
    gie <= 1'b1;
    wr(2'h0, 8'hd5);
    wr(2'h2, rnd());
    wait_done(sb);
    repeat (2) @(posedge clk);
    chk({7'h00, irq}, 8'h01);
    gie <= 1'b0;
    repeat (2) @(posedge clk);
    chk({7'h00, irq}, 8'h00);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    rd(2'h1, sb);
    chk(sb, 8'h00);
    sel_val <= 1'b1;
    $display("test flags done");
    wr(2'h0, 8'h15);
    wr(2'h2, rnd());
    repeat (64) @(posedge clk);
    rd(2'h1, sb);
    chk(sb, 8'h00);
    chk({7'h00, o_sck}, 8'h00);
    $display("test disabled done");
    sel_out <= 1'b0;
    wr(2'h0, 8'h55);
    sel_drv <= 1'b0;
    repeat (6) @(posedge clk);
    rd(2'h0, got);
    chk(got, 8'h45);
    rd(2'h1, sb);
    chk(sb, 8'h80);
    chk({6'h00, sck_oe_n, mosi_oe_n}, 8'h03);
    sel_drv <= 1'b1;
    rd(2'h2, got);
    wr(2'h0, 8'h55);
    rd(2'h0, got);
    chk(got, 8'h55);
    $display("test fault done");
    ctl = ctrl_s'(8'h43);
    wr(2'h0, ctl);
    peer_tx = rnd();
    wr(2'h2, peer_tx);
    repeat (8) @(posedge clk);
    chk({7'h00, miso_oe_n}, 8'h01);
    d1 = rnd();
    sxfer(d1, 8, got);
    chk(got, peer_tx);
    rd(2'h1, sb);
    chk(sb, 8'h80);
    rd(2'h2, got);
    chk(got, d1);
    sxfer(rnd(), 3, got);
    rd(2'h1, sb);
    chk(sb, 8'h00);
    d1 = rnd();
    sxfer(d1, 8, got);
    rd(2'h1, sb);
    rd(2'h2, got);
    chk(got, d1);
    $display("test slave done");
    end_sim();
  end
endmodule // spi_master_slave_port_test
